// *** shared/shr_pkg.sv ***
// Shared constants and types of the serial host register port.
// Assumes one 10 MHz clock domain; pins are synchronised inside the port.
//
// How it works
// - Write-increment command advances pointer; STOP advances too
// - Write-no-increment keeps pointer; table index steps at LUT_ADDR
// - Read-increment advances pointer per byte and STOP
// - Read-no-increment leaves pointer unchanged
// - Address is ten bits; instruction holds top two
// - Mode strap high selects 3-wire; low seven straps give the 2-wire device address
// - Drive strap picks 3-wire active or open-drain data output; 2-wire is always open-drain
// - Edge strap picks 3-wire launch and sample clock edges; 2-wire always samples on rise
// - Bytes go MSB first, stable before sampling edge
// - 3-wire frames carry no device address byte
// - Same four commands and pointer rules in 3-wire
// - Straps latched at reset release, held until reset
// - 2-wire first byte is address plus direction bit
// - Acknowledge every received byte when addressed in 2-wire, except a write byte while the FIFO is full
package shr_pkg;

	localparam int ADDR_W = 10;
	localparam int LUT_IDX_W = 8;
	localparam int STRAP_W = 8;

	localparam int STRAP_MODE = 7;
	localparam int STRAP_EDGE = 6;
	localparam int STRAP_DRIVE = 5;

	localparam logic [3:0] CMD_WR_INC = 4'h1;
	localparam logic [3:0] CMD_WR_NOINC = 4'h2;
	localparam logic [3:0] CMD_RD_INC = 4'h9;
	localparam logic [3:0] CMD_RD_NOINC = 4'hA;

	localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [1:0] CFG_LATCH_CYC = 2'h2;
	localparam logic [ADDR_W-1:0] LUT_ADDR_DEF = 10'h000;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_DEV = 5'h02,
		PH_INS = 5'h04,
		PH_ADR = 5'h08,
		PH_DATA = 5'h10
	} shr_phase_t;

	typedef struct packed {
		logic lut;
		logic [LUT_IDX_W-1:0] lut_index;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} shr_wr_req_t;

endpackage

// *** src/shr_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module shr_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import shr_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic has;
	} shr_fifo_st_t;

	shr_fifo_st_t q;
	shr_fifo_st_t d;
	logic push;
	logic pop;

	assign in_ready = q.cnt != FULL;
	assign out_valid = q.has;
	assign out_data = q.mem[q.rp];

	always_comb begin
		d = q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
		d.has = d.cnt != '0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	a_fifo_bound: assert property (@(posedge clk) disable iff (!nrst) q.cnt <= FULL)
		else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** src/shr_port.sv ***
// Serial host register port: 2-wire or 3-wire slave into a 10-bit register space.
// Assumes reg_read_data follows reg_address combinationally within one clock.
`timescale 1ns/1ps
`default_nettype none
module shr_port #(
	parameter logic [shr_pkg::ADDR_W-1:0] LUT_ADDR = shr_pkg::LUT_ADDR_DEF,
	parameter int DEPTH = shr_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic host_serial_clk,
	input wire logic host_serial_data_in,
	output logic host_serial_data_out,
	output logic host_serial_data_oe,
	input wire logic host_chip_select_n,
	input wire logic [shr_pkg::STRAP_W-1:0] memory_address_straps,
	output logic [shr_pkg::ADDR_W-1:0] reg_address,
	input wire logic [7:0] reg_read_data,
	output logic reg_read_strobe,
	output logic wr_valid,
	input wire logic wr_ready,
	output shr_pkg::shr_wr_req_t wr_req,
	output logic three_wire_mode,
	output logic write_overrun,
	input wire logic overrun_clear
);
	import shr_pkg::*;

	typedef struct packed {
		logic sck_m, sck_s, sck_p;
		logic sda_m, sda_s, sda_p;
		logic csn_m, csn_s, csn_p;
		logic [STRAP_W-1:0] strap_m;
		logic [STRAP_W-1:0] strap_s;
		logic [1:0] cfg_cnt;
		logic cfg_done;
		logic [STRAP_W-1:0] cfg;
		shr_phase_t phase;
		logic [3:0] cnt;
		logic [7:0] rx;
		logic [7:0] tx;
		logic [7:0] ins;
		logic [ADDR_W-1:0] ptr;
		logic [LUT_IDX_W-1:0] lut_idx;
		logic dir_rd;
		logic send;
		logic ack;
		logic load_pend;
		logic inc_pend;
		logic rd_strobe;
		logic overrun;
		logic out;
		logic oe;
	} shr_st_t;

	shr_st_t q;
	shr_st_t d;
	logic three, active_drv, samp, launch, rise, fall;
	logic start_ev, stop_ev, cs_fall, cs_rise, frame_ev;
	logic wr_cmd, rd_cmd, rd_step, push, fifo_ready, bit_now;
	logic [7:0] rx_byte;
	shr_wr_req_t push_req;

	////////////////////////////////////////////////////////////////////////
	// Edge and condition detection
	assign rise = q.sck_s && !q.sck_p;
	assign fall = !q.sck_s && q.sck_p;
	assign three = q.cfg[STRAP_MODE];
	assign active_drv = three && q.cfg[STRAP_DRIVE];
	assign samp = q.cfg_done && (!three || !q.csn_s) && ((!three || q.cfg[STRAP_EDGE]) ? rise : fall);
	assign launch = q.cfg_done && (!three || !q.csn_s) && ((!three || q.cfg[STRAP_EDGE]) ? fall : rise);
	assign start_ev = q.cfg_done && !three && q.sck_s && q.sck_p && q.sda_p && !q.sda_s;
	assign stop_ev = q.cfg_done && !three && q.sck_s && q.sck_p && !q.sda_p && q.sda_s;
	assign cs_fall = q.cfg_done && three && q.csn_p && !q.csn_s;
	assign cs_rise = q.cfg_done && three && !q.csn_p && q.csn_s;
	assign frame_ev = start_ev || stop_ev || cs_fall || cs_rise;
	assign rx_byte = {q.rx[6:0], q.sda_s};
	assign wr_cmd = q.ins[7:4] == CMD_WR_INC || q.ins[7:4] == CMD_WR_NOINC;
	assign rd_cmd = q.ins[7:4] == CMD_RD_INC || q.ins[7:4] == CMD_RD_NOINC;
	assign bit_now = q.tx[3'(BIT_LAST - q.cnt)];
	assign push_req = '{lut: q.ptr == LUT_ADDR, lut_index: q.lut_idx, addr: q.ptr, data: rx_byte};

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		d = q;
		push = 1'b0;
		rd_step = 1'b0;
		d.sck_m = host_serial_clk;
		d.sck_s = q.sck_m;
		d.sck_p = q.sck_s;
		d.sda_m = host_serial_data_in;
		d.sda_s = q.sda_m;
		d.sda_p = q.sda_s;
		d.csn_m = host_chip_select_n;
		d.csn_s = q.csn_m;
		d.csn_p = q.csn_s;
		d.strap_m = memory_address_straps;
		d.strap_s = q.strap_m;
		d.rd_strobe = 1'b0;
		if (!q.cfg_done) begin
			d.cfg_cnt = q.cfg_cnt + 1'b1;
			if (q.cfg_cnt == CFG_LATCH_CYC) begin
				d.cfg_done = 1'b1;
				d.cfg = q.strap_s;
			end
		end
		if (overrun_clear) begin
			d.overrun = 1'b0;
		end
		if (q.load_pend) begin
			d.tx = reg_read_data;
			d.load_pend = 1'b0;
			d.rd_strobe = 1'b1;
		end
		if (start_ev || cs_fall) begin
			d.phase = three ? PH_INS : PH_DEV;
			d.cnt = '0;
			d.send = 1'b0;
			d.ack = 1'b0;
			d.oe = 1'b0;
		end else if (stop_ev || cs_rise) begin
			d.phase = PH_IDLE;
			d.cnt = '0;
			d.send = 1'b0;
			d.ack = 1'b0;
			d.oe = 1'b0;
			d.inc_pend = 1'b0;
			if (q.inc_pend) begin
				d.ptr = q.ptr + 1'b1;
			end
		end else if (samp) begin
			if (q.cnt == BIT_ACK_SLOT) begin
				d.cnt = '0;
				if (q.send) begin
					rd_step = 1'b1;
					if (q.sda_s) begin
						d.send = 1'b0;
						d.phase = PH_IDLE;
					end else begin
						d.load_pend = 1'b1;
					end
				end else if (q.phase == PH_DATA && q.dir_rd && rd_cmd) begin
					d.send = 1'b1;
					d.load_pend = 1'b1;
				end
			end else begin
				d.rx = rx_byte;
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == BIT_LAST) begin
					if (three) begin
						d.cnt = '0;
					end
					if (q.send) begin
						if (three) begin
							rd_step = 1'b1;
							d.load_pend = 1'b1;
						end
					end else begin
						unique case (q.phase)
							PH_DEV: begin
								if (rx_byte[7:1] == q.cfg[6:0]) begin
									d.ack = 1'b1;
									d.dir_rd = rx_byte[0];
									d.phase = rx_byte[0] ? PH_DATA : PH_INS;
								end else begin
									d.phase = PH_IDLE;
								end
							end
							PH_INS: begin
								d.ins = rx_byte;
								d.ptr[9:8] = rx_byte[1:0];
								d.ack = 1'b1;
								d.dir_rd = 1'b0;
								d.phase = PH_ADR;
							end
							PH_ADR: begin
								d.ptr[7:0] = rx_byte;
								d.lut_idx = '0;
								d.inc_pend = 1'b0;
								d.ack = 1'b1;
								d.phase = PH_DATA;
								if (three && rd_cmd) begin
									d.send = 1'b1;
									d.dir_rd = 1'b1;
									d.load_pend = 1'b1;
								end
							end
							PH_DATA: begin
								if (!q.dir_rd && wr_cmd) begin
									if (fifo_ready) begin
										push = 1'b1;
										d.ack = 1'b1;
									end else begin
										d.overrun = 1'b1;
									end
								end else if (!q.dir_rd) begin
									d.ack = 1'b1;
								end
							end
							PH_IDLE: begin
							end
						endcase
					end
				end
			end
		end else if (launch) begin
			if (q.cnt == BIT_ACK_SLOT) begin
				d.oe = q.ack;
				d.out = 1'b0;
				d.ack = 1'b0;
			end else if (q.send) begin
				d.out = bit_now;
				d.oe = active_drv || !bit_now;
			end else begin
				d.oe = 1'b0;
				d.ack = 1'b0;
			end
		end
		if (push) begin
			if (q.ins[7:4] == CMD_WR_INC) begin
				d.ptr = q.ptr + 1'b1;
				d.inc_pend = 1'b1;
			end else if (q.ptr == LUT_ADDR) begin
				d.lut_idx = q.lut_idx + 1'b1;
			end
		end
		if (rd_step && q.ins[7:4] == CMD_RD_INC) begin
			d.ptr = q.ptr + 1'b1;
			d.inc_pend = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{phase: PH_IDLE, sck_m: 1'b1, sck_s: 1'b1, sck_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
				sda_p: 1'b1, csn_m: 1'b1, csn_s: 1'b1, csn_p: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write stream buffer and outputs
	shr_fifo #(.W($bits(shr_wr_req_t)), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_req),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wr_req)
	);

	assign host_serial_data_out = q.out;
	assign host_serial_data_oe = q.oe;
	assign reg_address = q.ptr;
	assign reg_read_strobe = q.rd_strobe;
	assign three_wire_mode = q.cfg[STRAP_MODE];
	assign write_overrun = q.overrun;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_frame_start;
		start_ev || cs_fall;
	endsequence

	sequence s_byte_restart;
		##1 (q.cnt == 4'h0 && !q.send && (q.phase == PH_DEV || q.phase == PH_INS));
	endsequence

	a_start_restart: assert property (@(posedge clk) disable iff (!nrst) s_frame_start |-> s_byte_restart)
		else $error("frame start did not restart byte tracking");
	a_wr_inc_step: assert property (@(posedge clk) disable iff (!nrst)
		push && q.ins[7:4] == CMD_WR_INC |=> q.ptr == $past(q.ptr) + 10'h001)
		else $error("write increment did not step pointer");
	a_wr_hold_ptr: assert property (@(posedge clk) disable iff (!nrst)
		push && q.ins[7:4] == CMD_WR_NOINC |=> $stable(q.ptr))
		else $error("write without increment moved pointer");
	a_lut_step: assert property (@(posedge clk) disable iff (!nrst)
		push && q.ins[7:4] == CMD_WR_NOINC && q.ptr == LUT_ADDR |=> q.lut_idx == $past(q.lut_idx) + 8'h01)
		else $error("table index did not step");
	a_rd_inc_step: assert property (@(posedge clk) disable iff (!nrst)
		rd_step && q.ins[7:4] == CMD_RD_INC |=> q.ptr == $past(q.ptr) + 10'h001)
		else $error("read increment did not step pointer");
	a_rd_reload: assert property (@(posedge clk) disable iff (!nrst)
		rd_step && (three || !q.sda_s) |=> ##1 q.rd_strobe)
		else $error("acknowledged read byte did not load next byte");
	a_rd_hold_ptr: assert property (@(posedge clk) disable iff (!nrst)
		rd_step && q.ins[7:4] == CMD_RD_NOINC |=> $stable(q.ptr))
		else $error("read without increment moved pointer");
	a_open_drain: assert property (@(posedge clk) disable iff (!nrst)
		q.oe && !(q.cfg[STRAP_MODE] && q.cfg[STRAP_DRIVE]) |-> !q.out)
		else $error("open drain pin driven high");
	a_cfg_held: assert property (@(posedge clk) disable iff (!nrst) q.cfg_done |=> $stable(q.cfg) && q.cfg_done)
		else $error("latched straps changed");
	a_no_reserved: assert property (@(posedge clk) disable iff (!nrst) push |-> wr_cmd && !q.dir_rd)
		else $error("register write on reserved or read command");
	a_ack_drive: assert property (@(posedge clk) disable iff (!nrst)
		launch && !frame_ev && q.cnt == BIT_ACK_SLOT && q.ack |=> q.oe && !q.out)
		else $error("acknowledge not driven low");
endmodule
`default_nettype wire

// *** testbench/shr_host_model.sv ***
// Serial bus master model for the host register port: 2-wire and 3-wire framing.
// Assumes the bench resolves the data wire with a pull-up and feeds it back on sda_w.
`timescale 1ns/1ps
`default_nettype none
module shr_host_model (
	input wire logic clk,
	input wire logic samp_rise,
	input wire logic sda_w,
	output logic scl,
	output logic sda_m,
	output logic cs_n
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		cs_n = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// 2-wire framing; clock stands high between transfers
	task automatic start();
		sda_m <= 1'b1;
		wt(4);
		scl <= 1'b1;
		wt(4);
		sda_m <= 1'b0;
		wt(4);
		scl <= 1'b0;
	endtask
	task automatic stop();
		wt(2);
		sda_m <= 1'b0;
		wt(2);
		scl <= 1'b1;
		wt(4);
		sda_m <= 1'b1;
		wt(4);
	endtask
	// Byte out MSB first, ninth slot driven with ackbit; reads send all ones
	task automatic byte2(input logic [7:0] d, input logic ackbit, output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			wt(2);
			sda_m <= (i == 0) ? ackbit : d[i-1];
			wt(2);
			scl <= 1'b1;
			wt(4);
			if (i > 0) q[i-1] = sda_w;
			ack = !sda_w;
			scl <= 1'b0;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// 3-wire framing; clock stands at launch level outside frames
	task automatic sel(input logic on);
		if (on) begin
			scl <= !samp_rise;
			wt(4);
			cs_n <= 1'b0;
		end else begin
			wt(4);
			cs_n <= 1'b1;
			sda_m <= 1'b1;
		end
		wt(4);
	endtask
	task automatic byte3(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			wt(2);
			sda_m <= d[i];
			wt(2);
			scl <= samp_rise;
			wt(4);
			q[i] = sda_w;
			scl <= !samp_rise;
		end
	endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the serial host register port in both wire protocols.
// Assumes the host model drives the link and a bench function answers register reads.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	import shr_pkg::*;
	localparam logic [9:0] LUT_AT = 10'h2C5;
	logic clk, nrst, scl, sda_m, cs_n, sda_w, d_out, d_oe, wr_valid, wr_ready, three_w, ovr, ovr_clr, sink_on, m3, rstb;
	logic [7:0] straps, rdata, s;
	logic [9:0] raddr, a;
	logic [6:0] dev;
	logic [7:0] dq[16];
	shr_wr_req_t wr_req;
	shr_wr_req_t got[$];
	int err_count, tests_run, nacks, seed, od_bad, rd_loads;
	function automatic logic [7:0] exp_rd(input logic [9:0] ad);
		return ad[7:0] ^ {ad[9:8], 6'h2D};
	endfunction
	always #50 clk = ~clk;
	assign sda_w = (d_oe ? d_out : 1'b1) & sda_m;
	assign rdata = exp_rd(raddr);
	shr_port #(.LUT_ADDR(LUT_AT)) dut_u (.clk(clk), .nrst(nrst), .host_serial_clk(scl),
		.host_serial_data_in(sda_w), .host_serial_data_out(d_out), .host_serial_data_oe(d_oe),
		.host_chip_select_n(cs_n), .memory_address_straps(straps), .reg_address(raddr), .reg_read_data(rdata),
		.reg_read_strobe(rstb), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req),
		.three_wire_mode(three_w), .write_overrun(ovr), .overrun_clear(ovr_clr));
	shr_host_model host_u (.clk(clk), .samp_rise(straps[6]), .sda_w(sda_w), .scl(scl), .sda_m(sda_m), .cs_n(cs_n));
	// Stalling consumer of the write stream, and open-drain watcher
	always @(posedge clk) begin
		wr_ready <= sink_on && (($random(seed) & 3) != 0);
		if (nrst && wr_valid && wr_ready) got.push_back(wr_req);
		if (nrst && rstb) rd_loads <= rd_loads + 1;
		if (nrst && d_oe && d_out && !(three_w && straps[5])) od_bad <= od_bad + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic note(input string t);
		$display("done: %s", t);
	endtask
	task automatic do_reset(input logic [7:0] st);
		nrst <= 1'b0;
		straps <= st;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task automatic send(input logic [7:0] b, input logic ackbit, output logic [7:0] q);
		logic k;
		if (m3) host_u.byte3(b, q);
		else begin
			host_u.byte2(b, ackbit, q, k);
			nacks += int'(!k);
		end
	endtask
	task automatic head(input logic [3:0] cmd, input logic [9:0] ad);
		logic [7:0] q;
		nacks = 0;
		if (m3) host_u.sel(1'b1);
		else begin
			host_u.start();
			send({dev, 1'b0}, 1'b1, q);
		end
		send({cmd, 2'b11, ad[9:8]}, 1'b1, q);
		send(ad[7:0], 1'b1, q);
	endtask
	task automatic tail();
		if (m3) host_u.sel(1'b0);
		else host_u.stop();
		host_u.wt(8);
	endtask
	task automatic wr_seq(input logic [3:0] cmd, input logic [9:0] ad, input int n);
		logic [7:0] q;
		head(cmd, ad);
		for (int i = 0; i < n; i++) begin
			dq[i] = 8'($random(seed));
			send(dq[i], 1'b1, q);
		end
		tail();
	endtask
	task automatic rd_seq(input logic [3:0] cmd, input logic [9:0] ad, input int n);
		logic [7:0] q;
		logic [9:0] e;
		rd_loads = 0;
		head(cmd, ad);
		if (!m3) begin
			host_u.start();
			send({dev, 1'b1}, 1'b1, q);
		end
		for (int i = 0; i < n; i++) begin
			send(8'hFF, i == n - 1, q);
			e = (cmd == CMD_RD_INC) ? ad + 10'(i) : ad;
			`CHK("read data", exp_rd(e), q)
		end
		tail();
		`CHK("read loads", m3 ? n + 1 : n, rd_loads)
	endtask
	task automatic chk_wr(input int n, input logic [9:0] ad, input logic inc, input logic lut);
		for (int t = 0; t < 400 && got.size() < n; t++) @(posedge clk);
		if (got.size() < n) begin
			err_count++;
			$display("BAD write count exp %0d got %0d", n, got.size());
			complete_run();
		end
		for (int i = 0; i < n; i++) begin
			`CHK("write addr", inc ? ad + 10'(i) : ad, got[i].addr)
			`CHK("write data", dq[i], got[i].data)
			`CHK("table flag", (inc ? ad + 10'(i) : ad) == LUT_AT, got[i].lut)
			if (lut) `CHK("table index", 8'(i), got[i].lut_index)
		end
		got.delete();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		straps = 8'h00;
		ovr_clr = 1'b0;
		wr_ready = 1'b0;
		sink_on = 1'b1;
		m3 = 1'b0;
		seed = 89;
		err_count = 0;
		tests_run = 0;
		od_bad = 0;
		s = 8'($random(seed));
		do_reset({1'b0, s[6:0]});
		dev = straps[6:0];
		`CHK("mode", 1'b0, three_w)
		a = 10'($random(seed));
		wr_seq(CMD_WR_INC, a, 3);
		`CHK("acks", 0, nacks)
		chk_wr(3, a, 1'b1, 1'b0);
		`CHK("pointer", a + 10'h4, raddr)
		wr_seq(CMD_WR_NOINC, LUT_AT, 4);
		chk_wr(4, LUT_AT, 1'b0, 1'b1);
		`CHK("pointer", LUT_AT, raddr)
		wr_seq(CMD_WR_NOINC, a, 1);
		chk_wr(1, a, 1'b0, 1'b0);
		`CHK("pointer", a, raddr)
		note("2-wire writes");
		rd_seq(CMD_RD_INC, a, 3);
		rd_seq(CMD_RD_NOINC, a, 2);
		`CHK("pointer", a, raddr)
		note("2-wire reads");
		dev = dev ^ 7'h01;
		wr_seq(CMD_WR_INC, a, 1);
		`CHK("acks", 4, nacks)
		dev = straps[6:0];
		wr_seq(4'h5, a, 2);
		`CHK("acks", 0, nacks)
		host_u.wt(20);
		`CHK("no writes", 0, got.size())
		note("ignored transfers");
		sink_on = 1'b0;
		wr_seq(CMD_WR_INC, a, 9);
		`CHK("acks", 1, nacks)
		`CHK("overrun", 1'b1, ovr)
		ovr_clr <= 1'b1;
		host_u.wt(1);
		ovr_clr <= 1'b0;
		host_u.wt(2);
		`CHK("overrun", 1'b0, ovr)
		sink_on = 1'b1;
		chk_wr(8, a, 1'b1, 1'b0);
		note("buffer full");
		m3 = 1'b1;
		for (int c = 0; c < 4; c++) begin
			s = 8'($random(seed));
			do_reset({1'b1, c[1:0], s[4:0]});
			straps <= {1'b0, straps[6:5], ~straps[4:0]};
			host_u.wt(2);
			`CHK("mode", 1'b1, three_w)
			a = 10'($random(seed));
			wr_seq(CMD_WR_INC, a, 2);
			chk_wr(2, a, 1'b1, 1'b0);
			rd_seq(CMD_RD_INC, a, 2);
			rd_seq(CMD_RD_NOINC, a + 10'h5, 2);
			note("3-wire strap setting");
		end
		`CHK("open drain", 0, od_bad)
		complete_run();
	end
endmodule
`default_nettype wire
